//--- verilog/drpc_pkg.sv
// drpc_pkg: constants for the refresh and power-down state control block
package drpc_pkg;
    // ------------------------------------------------------------------
    // command decode (cs_n, ras_n, cas_n, we_n)
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_REF  = 4'h1;   // L L L H
    localparam logic [3:0] CMD_NOP  = 4'h7;   // L H H H
    localparam logic [3:0] CMD_ACT  = 4'h3;   // L L H H
    localparam logic [3:0] CMD_PRE  = 4'h2;   // L L H L
    localparam logic [3:0] CMD_MRS  = 4'h0;   // L L L L
    // ------------------------------------------------------------------
    // mode bit positions
    // ------------------------------------------------------------------
    localparam int MR1_DLL_DIS_BIT = 0;       // mode register 1 bit A0
    localparam int MR0_PPD_BIT     = 12;      // mode register 0 bit A12
    localparam int MR_SEL_MR1      = 1;
    // ------------------------------------------------------------------
    // timing, clock rate and counter widths
    // ------------------------------------------------------------------
    localparam int CLK_MHZ         = 40;
    localparam int RFC_NS          = 160;     // refresh cycle time
    localparam int RFC_CYC         = (RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int SR_REFI_NS      = 7800;    // internal self-refresh interval
    localparam int SR_REFI_CYC     = (SR_REFI_NS * CLK_MHZ) / 1000;
    localparam int CKE_NS          = 5;       // first internal refresh bound
    localparam int CKE_CYC         = (CKE_NS * CLK_MHZ) / 1000 < 1 ? 1
                                     : (CKE_NS * CLK_MHZ) / 1000;
    localparam int CPDED_NS        = 25;      // receiver switch-off delay
    localparam int CPDED_CYC       = (CPDED_NS * CLK_MHZ + 999) / 1000;
    localparam int DLL_LOCK_CYC    = 512;     // dll relock after reset, core clock cycles
    localparam int CNT_W           = 16;
    localparam int ROW_W           = 16;
    localparam int BANKS           = 8;
    // ------------------------------------------------------------------
    // device power states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REFRESH,
        ST_SELF_REF,
        ST_PD_PRE,
        ST_PD_ACT
    } drpc_state_t;
endpackage

//--- verilog/drpc_edge_sync.sv
// drpc_edge_sync: three-stage pin synchroniser with rising edge detect
`timescale 1ns/100ps
`default_nettype none
module drpc_edge_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire  logic         core_clk,
    input  wire  logic         reset,
    // pins in, settled level and rise out
    input  wire  logic [W-1:0] pin_in,
    output var   logic [W-1:0] level_out,
    output var   logic         rise_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_d;
    logic [W-1:0] lvl_q;
    logic         rise_d;
    logic         rise_q;

    // accept a change once stages two and three agree
    always_comb begin
        lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
        rise_d = (s2_q == s3_q) && !lvl_q[0] && s3_q[0];
    end

    // stage registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            lvl_q  <= '0;
            rise_q <= 1'b0;
        end else begin
            s1_q   <= pin_in;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            lvl_q  <= lvl_d;
            rise_q <= rise_d;
        end
    end

    assign level_out = lvl_q;
    assign rise_out  = rise_q;
endmodule
`default_nettype wire

//--- verilog/drpc_top.sv
// drpc_top: refresh, self-refresh and power-down state control of the memory device
//
// What this block does
// - refresh decoded: cs ras cas low, we high
// - internal row counter; banks idle after refresh
// - self-refresh entry decoded with cke low
// - dll off on entry, reset on exit, unless mode register 1 A0 disables the dll
// - ignore commands; internal timer refresh quickly
// - exit is cke high with nop
// - power-down is cke low with nop
// - precharge or active power-down by banks
// - receivers off after delay in power-down
// - mode bit chooses slow or fast exit from precharge power-down; active power-down exit is always fast
`timescale 1ns/100ps
`default_nettype none
module drpc_top
    import drpc_pkg::*;
#(
    parameter int SR_REFI_CYCLES = SR_REFI_CYC,
    parameter int DLL_LOCK_CYCLES = DLL_LOCK_CYC
) (
    // clock and reset
    input  wire  logic             core_clk,
    input  wire  logic             reset,
    // memory link pins from the controller
    input  wire  logic             ck_pin,
    input  wire  logic             cke_pin,
    input  wire  logic             cs_n_pin,
    input  wire  logic             ras_n_pin,
    input  wire  logic             cas_n_pin,
    input  wire  logic             we_n_pin,
    input  wire  logic [2:0]       ba_pin,
    input  wire  logic [ROW_W-1:0] addr_pin,
    // device state seen by the rest of the core
    output var   logic             refresh_busy,
    output var   logic             refresh_pulse,
    output var   logic [ROW_W-1:0] refresh_row,
    output var   logic             self_refresh,
    output var   logic             power_down_pre,
    output var   logic             power_down_act,
    output var   logic             slow_exit,
    output var   logic             rx_enable,
    output var   logic             dll_enable,
    output var   logic             dll_reset,
    output var   logic [BANKS-1:0] bank_open
);
    // ------------------------------------------------------------------
    // pin synchronisers; command sampled at each ck rising edge
    // ------------------------------------------------------------------
    localparam int PW = 5 + 3 + ROW_W;
    logic [PW-1:0] pins_s;
    logic          ck_rise;

    drpc_edge_sync #(.W(PW)) u_sync_cmd (
        .core_clk  (core_clk),
        .reset     (reset),
        .pin_in    ({cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, ba_pin, addr_pin}),
        .level_out (pins_s),
        .rise_out  ()
    );
    drpc_edge_sync #(.W(1)) u_sync_ck (
        .core_clk  (core_clk),
        .reset     (reset),
        .pin_in    (ck_pin),
        .level_out (),
        .rise_out  (ck_rise)
    );

    logic             cke_s;
    logic [3:0]       cmd_s;
    logic [2:0]       ba_s;
    logic [ROW_W-1:0] addr_s;
    assign cke_s  = pins_s[PW-1];
    assign cmd_s  = pins_s[PW-2 -: 4];
    assign ba_s   = pins_s[ROW_W +: 3];
    assign addr_s = pins_s[ROW_W-1:0];

    // nop or deselect decode, used at several places
    function automatic logic is_nop(input logic [3:0] c);
        return (c == CMD_NOP) || c[3];
    endfunction

    // clock enable registered high at the last ck edge and low at this one
    function automatic logic cke_fell(input logic prev, input logic cur);
        return prev && !cur;
    endfunction

    // leaving power-down or self-refresh: clock enable high with nop or deselect
    function automatic logic is_exit(input logic k, input logic [3:0] c);
        return k && is_nop(c);
    endfunction

    // ------------------------------------------------------------------
    // state and counters
    // ------------------------------------------------------------------
    drpc_state_t      state_q, state_d;
    logic             cke_prev_q, cke_prev_d;
    logic [CNT_W-1:0] tmr_q, tmr_d;     // refresh cycle / internal timer
    logic [CNT_W-1:0] cpd_q, cpd_d;     // receiver switch-off delay
    logic [CNT_W-1:0] dll_q, dll_d;     // dll reset hold
    logic [ROW_W-1:0] row_q, row_d;
    logic [BANKS-1:0] bank_q, bank_d;
    logic             dll_dis_q, dll_dis_d;   // mode register 1 A0
    logic             ppd_fast_q, ppd_fast_d; // mode register 0 A12
    logic             sr_first_q, sr_first_d;
    logic             pulse_d, pulse_q;
    logic             rx_d, rx_q;
    logic             slow_d, slow_q;
    logic             dllen_d, dllen_q;

    // next state: command decode per ck edge
    always_comb begin
        state_d    = state_q;
        cke_prev_d = cke_prev_q;
        tmr_d      = tmr_q;
        cpd_d      = cpd_q;
        dll_d      = (dll_q != '0) ? dll_q - 1'b1 : dll_q;
        row_d      = row_q;
        bank_d     = bank_q;
        dll_dis_d  = dll_dis_q;
        ppd_fast_d = ppd_fast_q;
        sr_first_d = sr_first_q;
        pulse_d    = 1'b0;
        rx_d       = rx_q;
        slow_d     = slow_q;
        dllen_d    = dllen_q;
        if (ck_rise) begin
            cke_prev_d = cke_s;
            case (state_q)
                ST_IDLE: begin
                    if (cke_fell(cke_prev_q, cke_s) && cmd_s == CMD_REF) begin
                        state_d    = ST_SELF_REF;
                        tmr_d      = CNT_W'(CKE_CYC);
                        sr_first_d = 1'b1;
                        bank_d     = '0;
                        rx_d       = 1'b0;
                        if (!dll_dis_q) dllen_d = 1'b0;
                    end else if (cke_fell(cke_prev_q, cke_s) && is_nop(cmd_s)) begin
                        state_d = (bank_q == '0) ? ST_PD_PRE : ST_PD_ACT;
                        cpd_d   = CNT_W'(CPDED_CYC);
                        slow_d  = (bank_q == '0) && !ppd_fast_q;
                        if (slow_d) dllen_d = 1'b0;
                    end else if (cke_s && cmd_s == CMD_REF) begin
                        state_d = ST_REFRESH;
                        tmr_d   = CNT_W'(RFC_CYC);
                        pulse_d = 1'b1;
                        row_d   = row_q + 1'b1;
                    end else if (cke_s && cmd_s == CMD_ACT) begin
                        bank_d[ba_s] = 1'b1;
                    end else if (cke_s && cmd_s == CMD_PRE) begin
                        if (addr_s[10]) bank_d = '0;
                        else bank_d[ba_s] = 1'b0;
                    end else if (cke_s && cmd_s == CMD_MRS) begin
                        if (ba_s == 3'(MR_SEL_MR1)) dll_dis_d = addr_s[MR1_DLL_DIS_BIT];
                        else if (ba_s == 3'h0) ppd_fast_d = addr_s[MR0_PPD_BIT];
                    end
                end
                ST_PD_PRE, ST_PD_ACT: begin
                    if (is_exit(cke_s, cmd_s)) begin
                        state_d = ST_IDLE;
                        rx_d    = 1'b1;
                        if (slow_q) begin
                            dllen_d = 1'b1;
                            dll_d   = CNT_W'(DLL_LOCK_CYCLES);
                        end
                        slow_d = 1'b0;
                    end
                end
                ST_SELF_REF: begin
                    if (is_exit(cke_s, cmd_s)) begin
                        state_d = ST_IDLE;
                        rx_d    = 1'b1;
                        sr_first_d = 1'b0;
                        // an exit before the first internal tick still refreshes a row
                        if (sr_first_q) begin
                            pulse_d = 1'b1;
                            row_d   = row_q + 1'b1;
                        end
                        if (!dll_dis_q) begin
                            dllen_d = 1'b1;
                            dll_d   = CNT_W'(DLL_LOCK_CYCLES);
                        end
                    end
                end
                ST_REFRESH: begin
                    // commands during the refresh cycle are ignored
                    // a second refresh is refused while busy
                end
                default: state_d = ST_IDLE;
            endcase
        end
        // core-clock timers: refresh cycle end, internal refresh, receivers
        case (state_q)
            ST_REFRESH: begin
                if (tmr_q <= CNT_W'(1)) begin
                    state_d = ST_IDLE;
                    bank_d  = '0;
                end else begin
                    tmr_d = tmr_q - 1'b1;
                end
            end
            ST_SELF_REF: begin
                if (state_d == ST_SELF_REF) begin
                    if (tmr_q <= CNT_W'(1)) begin
                        pulse_d    = 1'b1;
                        row_d      = row_q + 1'b1;
                        tmr_d      = CNT_W'(SR_REFI_CYCLES);
                        sr_first_d = 1'b0;
                    end else begin
                        tmr_d = tmr_q - 1'b1;
                    end
                end
            end
            ST_PD_PRE, ST_PD_ACT: begin
                if (cpd_q != '0) begin
                    cpd_d = cpd_q - 1'b1;
                    if (cpd_q == CNT_W'(1)) rx_d = 1'b0;
                end
            end
            default: begin
            end
        endcase
    end

    // state registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q    <= ST_IDLE;
            cke_prev_q <= 1'b0;
            tmr_q      <= '0;
            cpd_q      <= '0;
            dll_q      <= '0;
            row_q      <= '0;
            bank_q     <= '0;
            dll_dis_q  <= 1'b0;
            ppd_fast_q <= 1'b0;
            sr_first_q <= 1'b0;
            pulse_q    <= 1'b0;
            rx_q       <= 1'b1;
            slow_q     <= 1'b0;
            dllen_q    <= 1'b1;
        end else begin
            state_q    <= state_d;
            cke_prev_q <= cke_prev_d;
            tmr_q      <= tmr_d;
            cpd_q      <= cpd_d;
            dll_q      <= dll_d;
            row_q      <= row_d;
            bank_q     <= bank_d;
            dll_dis_q  <= dll_dis_d;
            ppd_fast_q <= ppd_fast_d;
            sr_first_q <= sr_first_d;
            pulse_q    <= pulse_d;
            rx_q       <= rx_d;
            slow_q     <= slow_d;
            dllen_q    <= dllen_d;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    logic o_busy_q, o_sr_q, o_pdp_q, o_pda_q, o_dllrst_q;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            o_busy_q   <= 1'b0;
            o_sr_q     <= 1'b0;
            o_pdp_q    <= 1'b0;
            o_pda_q    <= 1'b0;
            o_dllrst_q <= 1'b0;
        end else begin
            o_busy_q   <= (state_d == ST_REFRESH);
            o_sr_q     <= (state_d == ST_SELF_REF);
            o_pdp_q    <= (state_d == ST_PD_PRE);
            o_pda_q    <= (state_d == ST_PD_ACT);
            o_dllrst_q <= (dll_d != '0);
        end
    end

    assign refresh_busy   = o_busy_q;
    assign refresh_pulse  = pulse_q;
    assign refresh_row    = row_q;
    assign self_refresh   = o_sr_q;
    assign power_down_pre = o_pdp_q;
    assign power_down_act = o_pda_q;
    assign slow_exit      = slow_q;
    assign rx_enable      = rx_q;
    assign dll_enable     = dllen_q;
    assign dll_reset      = o_dllrst_q;
    assign bank_open      = bank_q;
endmodule
`default_nettype wire

//--- tb/drpc_top_props.sv
// drpc_top_props: assertions on the state outputs of the refresh and power-down block
`timescale 1ns/100ps
`default_nettype none
module drpc_top_chk
    import drpc_pkg::*;
(
    // clock and reset
    input wire logic             core_clk,
    input wire logic             reset,
    // watched outputs
    input wire logic             refresh_busy,
    input wire logic             refresh_pulse,
    input wire logic [ROW_W-1:0] refresh_row,
    input wire logic             self_refresh,
    input wire logic             power_down_pre,
    input wire logic             power_down_act,
    input wire logic             slow_exit,
    input wire logic             rx_enable,
    input wire logic             dll_enable,
    input wire logic             dll_reset,
    input wire logic [BANKS-1:0] bank_open
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_row_step;
        refresh_pulse |-> refresh_row == $past(refresh_row) + 16'h0001;
    endproperty
    a_row_step: assert property (p_row_step)
        else $error("row counter did not step");
    property p_busy_len;
        $rose(refresh_busy) |-> refresh_pulse ##1 refresh_busy[*5] ##[1:2] !refresh_busy;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("refresh cycle length wrong");
    property p_banks_idle;
        $fell(refresh_busy) |-> bank_open == '0;
    endproperty
    a_banks_idle: assert property (p_banks_idle)
        else $error("banks open after refresh");
    property p_sr_entry;
        $rose(self_refresh) |-> !rx_enable && !dll_reset && !(power_down_pre | power_down_act);
    endproperty
    a_sr_entry: assert property (p_sr_entry)
        else $error("receivers on in self refresh");
    property p_sr_first;
        $rose(self_refresh) |-> ##[0:2] refresh_pulse;
    endproperty
    a_sr_first: assert property (p_sr_first)
        else $error("no early internal refresh");
    property p_sr_exit;
        $fell(self_refresh) |-> rx_enable && (dll_reset == dll_enable);
    endproperty
    a_sr_exit: assert property (p_sr_exit)
        else $error("self refresh exit wrong");
    property p_pd_type;
        (power_down_pre | power_down_act) |-> power_down_act == (bank_open != '0);
    endproperty
    a_pd_type: assert property (p_pd_type)
        else $error("power-down kind wrong");
    property p_pd_rx;
        $rose(power_down_pre | power_down_act) |-> ##1 !rx_enable;
    endproperty
    a_pd_rx: assert property (p_pd_rx)
        else $error("receivers not off");
    property p_slow;
        $rose(slow_exit) |-> power_down_pre ##[0:1] !dll_enable;
    endproperty
    a_slow: assert property (p_slow)
        else $error("slow exit with dll on");
endmodule
bind drpc_top drpc_top_chk i_chk (.core_clk, .reset, .refresh_busy, .refresh_pulse,
    .refresh_row, .self_refresh, .power_down_pre, .power_down_act, .slow_exit,
    .rx_enable, .dll_enable, .dll_reset, .bank_open);
`default_nettype wire

//--- tb/drpc_ctl_model.sv
// drpc_ctl_model: memory controller model driving clock, clock enable and commands
`timescale 1ns/100ps
`default_nettype none
module drpc_ctl_model
    import drpc_pkg::*;
(
    // link clock and clock enable
    output var logic             ck,
    output var logic             cke,
    // command, bank and address
    output var logic [3:0]       cmd,
    output var logic [2:0]       ba,
    output var logic [ROW_W-1:0] addr
);
    logic run;
    // idle values
    initial begin
        ck = 1'b0;
        run = 1'b0;
        cke = 1'b1;
        cmd = CMD_NOP;
        ba = 3'h0;
        addr = 16'h5A5A;
    end
    // link clock, stands low while stopped
    always begin
        #100;
        ck = run ? ~ck : 1'b0;
    end
    // one command held from a falling edge to the next falling edge
    task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
                         input logic [ROW_W-1:0] a);
        @(negedge ck);
        #1;
        cke = k;
        cmd = c;
        ba = b;
        addr = a;
        @(posedge ck);
        @(negedge ck);
        #1;
        cmd = CMD_NOP;
        ba = ~b;
        addr = ~a;
    endtask
endmodule
`default_nettype wire

//--- tb/tb_drpc_top.sv
// tb_drpc_top: self-checking bench for the refresh and power-down block
`timescale 1ns/100ps
`default_nettype none
module tb_drpc_top;
    import drpc_pkg::*;
    logic             core_clk;
    logic             reset;
    wire logic        ck;
    wire logic        cke;
    wire logic [3:0]  cmd;
    wire logic [2:0]  ba;
    wire logic [15:0] addr;
    logic             refresh_busy;
    logic             refresh_pulse;
    logic [15:0]      refresh_row;
    logic             self_refresh;
    logic             power_down_pre;
    logic             power_down_act;
    logic             slow_exit;
    logic             rx_enable;
    logic             dll_enable;
    logic             dll_reset;
    logic [7:0]       bank_open;
    int               n_mismatch;
    int               num_checks;
    int               n_pulse;
    int               n_cyc;

    drpc_top #(.SR_REFI_CYCLES(20), .DLL_LOCK_CYCLES(8)) i_dut (.core_clk, .reset,
        .ck_pin(ck), .cke_pin(cke), .cs_n_pin(cmd[3]), .ras_n_pin(cmd[2]),
        .cas_n_pin(cmd[1]), .we_n_pin(cmd[0]), .ba_pin(ba), .addr_pin(addr),
        .refresh_busy, .refresh_pulse, .refresh_row, .self_refresh, .power_down_pre,
        .power_down_act, .slow_exit, .rx_enable, .dll_enable, .dll_reset, .bank_open);
    drpc_ctl_model i_ctl (.ck, .cke, .cmd, .ba, .addr);

    // core clock
    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;
    // counts refresh pulses and cuts a hang short
    always @(posedge core_clk) begin
        n_cyc++;
        if (refresh_pulse === 1'b1) n_pulse++;
        if (n_cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one command on one link clock edge, then outputs settle
    task automatic send(input logic k, input logic [3:0] c, input logic [2:0] b,
                        input logic [15:0] a);
        i_ctl.issue(k, c, b, a);
        repeat (6) @(posedge core_clk);
        #2;
    endtask

    task automatic t_refresh();
        int p0;
        send(1'b1, CMD_ACT, 3'h3, 16'h0000);
        check(bank_open, 32'h08);
        send(1'b1, CMD_PRE, 3'h0, 16'h0400);
        check(bank_open, 32'h00);
        p0 = n_pulse;
        send(1'b1, 4'h9, 3'h5, 16'hFFFF);
        check(n_pulse - p0, 0);
        send(1'b1, CMD_REF, 3'h5, 16'hFFFF);
        check(n_pulse - p0, 1);
        check(refresh_row, 32'h1);
        send(1'b1, CMD_NOP, 3'h0, 16'h0000);
        check(bank_open, 32'h0);
    endtask

    task automatic t_self_refresh();
        int p0;
        logic [15:0] r0;
        p0 = n_pulse;
        send(1'b0, CMD_REF, 3'h0, 16'h0000);
        check({self_refresh, rx_enable, dll_enable}, 3'b100);
        check(n_pulse - p0, 1);
        send(1'b0, CMD_ACT, 3'h5, 16'h0000);
        check(bank_open, 32'h0);
        i_ctl.run = 1'b0;
        repeat (200) @(posedge core_clk);
        #2;
        check(n_pulse - p0 > 10, 1);
        i_ctl.run = 1'b1;
        repeat (40) @(posedge core_clk);
        send(1'b1, CMD_NOP, 3'h0, 16'h0000);
        check({self_refresh, rx_enable, dll_enable, dll_reset}, 4'b0111);
        repeat (12) @(posedge core_clk);
        #2;
        check(dll_reset, 0);
        r0 = refresh_row;
        send(1'b1, CMD_REF, 3'h0, 16'h0000);
        check(refresh_row, r0 + 16'h0001);
    endtask

    task automatic t_power_down();
        logic [3:0] exp_st [3];
        logic [7:0] exp_bk [3];
        exp_st = '{4'b1010, 4'b1001, 4'b0101};
        exp_bk = '{8'h00, 8'h00, 8'h02};
        for (int i = 0; i < 3; i++) begin
            if (i == 1) send(1'b1, CMD_MRS, 3'h0, 16'h1000);
            if (i == 2) send(1'b1, CMD_ACT, 3'h1, 16'h0000);
            send(1'b1, CMD_NOP, 3'h0, 16'h0000);
            send(1'b0, CMD_NOP, 3'h0, 16'h0000);
            check({power_down_pre, power_down_act, slow_exit, dll_enable}, exp_st[i]);
            check({rx_enable, bank_open}, {1'b0, exp_bk[i]});
            send(1'b0, CMD_PRE, 3'h1, 16'h0400);
            check(bank_open, exp_bk[i]);
            send(1'b1, CMD_NOP, 3'h0, 16'h0000);
            check({power_down_pre, power_down_act, rx_enable, dll_enable}, 4'b0011);
        end
    endtask

    // reset, then the scenarios
    initial begin
        reset = 1'b1;
        repeat (2) @(posedge core_clk);
        #2;
        check({rx_enable, dll_enable, self_refresh, refresh_busy, refresh_row}, 20'hC0000);
        reset = 1'b0;
        repeat (8) @(posedge core_clk);
        i_ctl.run = 1'b1;
        send(1'b1, CMD_NOP, 3'h0, 16'h0000);
        t_refresh();
        t_self_refresh();
        t_power_down();
        report_and_stop();
    end
endmodule
`default_nettype wire
